// *** inc/vpe_pkg.sv ***
// Shared constants, types and the magnitude estimator of the voltage protection block.
`default_nettype none
package vpe_pkg;

	// ******************************************************
	// Timing
	// ******************************************************
	localparam int CLK_MHZ = 200;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int STEP_TIME_MS = 10;
	localparam int STEP_CYCLES = (STEP_TIME_MS * 1000 * 1000) / (CLK_PERIOD_PS / 1000);
	localparam int DELAY_MAX_TIME_CS = 60000;

	// ******************************************************
	// Widths
	// ******************************************************
	localparam int VW = 16;
	localparam int SUMW = 18;
	localparam int PW = 12;
	localparam int NW = 16;
	localparam int DW = 16;
	localparam int LW = 32;
	localparam int AW = 48;
	localparam int TCW = 32;

	// ******************************************************
	// Scaling and reset values
	// ******************************************************
	localparam logic [DW-1:0] DELAY_MAX_STEPS = 16'hea60;
	localparam logic [LW-1:0] PU_SCALE = 32'h0000_03e8;
	localparam logic [SUMW+7:0] MAG_ALPHA = 26'h000_007b;
	localparam logic [SUMW+7:0] MAG_BETA = 26'h000_0033;
	localparam int MAG_SHIFT = 7;
	localparam logic [AW-1:0] ACC_RESET = 48'h0000_0000_0000;
	localparam logic [TCW-1:0] TICK_RESET = 32'h0000_0000;
	localparam logic [DW-1:0] TICKS_SEEN_MAX = 16'hffff;

	typedef enum logic [1:0] {
		VPE_IDLE,
		VPE_TIMING,
		VPE_OPERATED
	} vpe_state_t;

	// Magnitude of a phasor estimated as alpha*max + beta*min, never below max.
	function automatic logic [SUMW-1:0] vpe_mag(input logic signed [SUMW-1:0] re, input logic signed [SUMW-1:0] im);
		logic [SUMW-1:0] a;
		logic [SUMW-1:0] b;
		logic [SUMW-1:0] mx;
		logic [SUMW-1:0] mn;
		logic [SUMW+7:0] est;
		a = re[SUMW-1] ? $unsigned(-re) : $unsigned(re);
		b = im[SUMW-1] ? $unsigned(-im) : $unsigned(im);
		mx = (a > b) ? a : b;
		mn = (a > b) ? b : a;
		est = ((SUMW+8)'(mx) * MAG_ALPHA + (SUMW+8)'(mn) * MAG_BETA) >> MAG_SHIFT;
		return (est[SUMW-1:0] > mx) ? est[SUMW-1:0] : mx;
	endfunction

endpackage
`default_nettype wire

// *** src/vpe_timer.sv ***
// One voltage element: threshold test, definite or inverse delay and its flags.
`timescale 1ns/10ps
`default_nettype none
module vpe_timer (
	input wire logic clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic enable,
	input wire logic block,
	input wire logic over,
	input wire logic inverse,
	input wire logic [vpe_pkg::LW-1:0] level,
	input wire logic [vpe_pkg::LW-1:0] setpoint,
	input wire logic [vpe_pkg::LW-1:0] min_level,
	input wire logic [vpe_pkg::DW-1:0] delay,
	output logic pickup,
	output logic operate
);
	import vpe_pkg::*;

	vpe_state_t state, next_state;
	logic [AW-1:0] acc, next_acc;
	logic next_pickup, next_operate;
	logic cond, active, use_inv;
	logic [AW-1:0] target, step, sum;
	logic [DW-1:0] ticks_seen, next_ticks_seen;

	// ******************************************************
	// Threshold and timer
	// ******************************************************
	always_comb begin
		use_inv = inverse && !over;
		cond = over ? (level > setpoint) : ((level < setpoint) && (level >= min_level));
		active = enable && !block && cond;
		target = use_inv ? AW'(delay) * AW'(setpoint) : AW'(delay);
		step = use_inv ? AW'(setpoint - level) : AW'(1);
		sum = acc + step;
		next_state = state;
		next_acc = acc;
		next_pickup = active;
		next_operate = operate;
		next_ticks_seen = ticks_seen;
		if (!active) begin
			next_state = VPE_IDLE;
			next_acc = ACC_RESET;
			next_operate = 1'b0;
			next_ticks_seen = '0;
		end else begin
			case (state)
				VPE_IDLE: begin
					next_acc = ACC_RESET;
					if (target == ACC_RESET) begin
						next_state = VPE_OPERATED;
						next_operate = 1'b1;
					end else begin
						next_state = VPE_TIMING;
					end
				end
				VPE_TIMING: begin
					if (tick) begin
						if (ticks_seen != TICKS_SEEN_MAX) begin
							next_ticks_seen = ticks_seen + 1'b1;
						end
						if (sum >= target) begin
							next_state = VPE_OPERATED;
							next_acc = target;
							next_operate = 1'b1;
						end else begin
							next_acc = sum;
						end
					end
				end
				VPE_OPERATED: begin
					next_operate = 1'b1;
				end
				default: begin
					next_state = VPE_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= VPE_IDLE;
			acc <= ACC_RESET;
			pickup <= 1'b0;
			operate <= 1'b0;
			ticks_seen <= '0;
		end else begin
			state <= next_state;
			acc <= next_acc;
			pickup <= next_pickup;
			operate <= next_operate;
			ticks_seen <= next_ticks_seen;
		end
	end

	// ******************************************************
	// Checks
	// ******************************************************
	property p_min_time;
		@(posedge clk) disable iff (rst) $rose(operate) && (delay != '0) |-> ticks_seen >= $past(delay);
	endproperty
	a_min_time: assert property (p_min_time) else $error("Element operated before its delay setting.");

	property p_definite_exact;
		@(posedge clk) disable iff (rst) $rose(operate) && !$past(use_inv) |-> ticks_seen == $past(delay);
	endproperty
	a_definite_exact: assert property (p_definite_exact) else $error("Definite delay not equal to setting.");

	property p_instant;
		@(posedge clk) disable iff (rst) active && (delay == '0) && (state == VPE_IDLE) |=> operate;
	endproperty
	a_instant: assert property (p_instant) else $error("Zero delay did not operate at once.");

	property p_reset_clear;
		@(posedge clk) disable iff (rst) !active |=> !operate && !pickup && (acc == ACC_RESET);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("Element did not reset on recovery.");

	property p_op_needs_pickup;
		@(posedge clk) disable iff (rst) operate |-> pickup;
	endproperty
	a_op_needs_pickup: assert property (p_op_needs_pickup) else $error("Operate without pickup.");

	property p_disabled;
		@(posedge clk) disable iff (rst) (!enable || block) |=> !pickup && !operate;
	endproperty
	a_disabled: assert property (p_disabled) else $error("Disabled or blocked element still asserted.");

endmodule
`default_nettype wire

// *** src/vpe_top.sv ***
// Voltage protection elements: phase and auxiliary under and overvoltage, neutral overvoltage.
`timescale 1ns/10ps
`default_nettype none
module vpe_top #(
	parameter int STEP_CYCLES_P = vpe_pkg::STEP_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic vt_delta,
	input wire logic phase_uv_phase_to_phase,
	input wire logic signed [vpe_pkg::VW-1:0] va_re,
	input wire logic signed [vpe_pkg::VW-1:0] va_im,
	input wire logic signed [vpe_pkg::VW-1:0] vb_re,
	input wire logic signed [vpe_pkg::VW-1:0] vb_im,
	input wire logic signed [vpe_pkg::VW-1:0] vc_re,
	input wire logic signed [vpe_pkg::VW-1:0] vc_im,
	input wire logic signed [vpe_pkg::VW-1:0] vx_re,
	input wire logic signed [vpe_pkg::VW-1:0] vx_im,
	input wire logic [vpe_pkg::NW-1:0] phase_transformer_nominal_secondary,
	input wire logic [vpe_pkg::NW-1:0] aux_transformer_nominal_secondary,
	input wire logic phase_uv_enable,
	input wire logic phase_uv_block,
	input wire logic phase_uv_inverse,
	input wire logic [vpe_pkg::PW-1:0] phase_uv_pickup_level,
	input wire logic [vpe_pkg::PW-1:0] phase_uv_min_level,
	input wire logic [vpe_pkg::DW-1:0] phase_uv_delay_time,
	input wire logic phase_ov_enable,
	input wire logic phase_ov_block,
	input wire logic [vpe_pkg::PW-1:0] phase_ov_pickup_level,
	input wire logic [vpe_pkg::DW-1:0] phase_ov_delay_time,
	input wire logic neutral_ov_enable,
	input wire logic neutral_ov_block,
	input wire logic [vpe_pkg::PW-1:0] neutral_ov_pickup_level,
	input wire logic [vpe_pkg::DW-1:0] neutral_ov_delay_time,
	input wire logic aux_uv_enable,
	input wire logic aux_uv_block,
	input wire logic aux_uv_inverse,
	input wire logic [vpe_pkg::PW-1:0] aux_under_pickup_level,
	input wire logic [vpe_pkg::PW-1:0] aux_under_min_level,
	input wire logic [vpe_pkg::DW-1:0] aux_under_delay_time,
	input wire logic aux_ov_enable,
	input wire logic aux_ov_block,
	input wire logic [vpe_pkg::PW-1:0] aux_ov_pickup_level,
	input wire logic [vpe_pkg::DW-1:0] aux_ov_delay_time,
	output logic [2:0] phase_uv_pickup,
	output logic [2:0] phase_uv_phase_operate,
	output logic phase_uv_operate,
	output logic [2:0] phase_ov_pickup,
	output logic [2:0] phase_ov_phase_operate,
	output logic phase_ov_operate,
	output logic neutral_ov_pickup,
	output logic neutral_ov_operate,
	output logic aux_uv_pickup,
	output logic aux_uv_operate,
	output logic aux_ov_pickup,
	output logic aux_ov_operate
);
	import vpe_pkg::*;

	// ******************************************************
	// Step divider
	// ******************************************************
	logic [TCW-1:0] tick_cnt, next_tick_cnt;
	logic tick, next_tick;

	always_comb begin
		next_tick = 1'b0;
		next_tick_cnt = tick_cnt + 1'b1;
		if (tick_cnt >= TCW'(STEP_CYCLES_P - 1)) begin
			next_tick_cnt = TICK_RESET;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_cnt <= TICK_RESET;
			tick <= 1'b0;
		end else begin
			tick_cnt <= next_tick_cnt;
			tick <= next_tick;
		end
	end

	// ******************************************************
	// Measured quantities
	// ******************************************************
	logic signed [SUMW-1:0] pre [3];
	logic signed [SUMW-1:0] pim [3];
	logic signed [SUMW-1:0] dre [3];
	logic signed [SUMW-1:0] dim [3];
	logic [SUMW-1:0] mag_pg [3];
	logic [SUMW-1:0] mag_pp [3];
	logic [SUMW-1:0] mag_n, mag_x;
	logic [LW-1:0] next_uv_level [3];
	logic [LW-1:0] next_ov_level [3];
	logic [LW-1:0] next_n_level, next_x_level;
	logic [LW-1:0] uv_level [3];
	logic [LW-1:0] ov_level [3];
	logic [LW-1:0] n_level, x_level;

	always_comb begin
		pre[0] = SUMW'(va_re);
		pim[0] = SUMW'(va_im);
		pre[1] = SUMW'(vb_re);
		pim[1] = SUMW'(vb_im);
		pre[2] = SUMW'(vc_re);
		pim[2] = SUMW'(vc_im);
		for (int i = 0; i < 3; i++) begin
			dre[i] = pre[i] - pre[(i + 1) % 3];
			dim[i] = pim[i] - pim[(i + 1) % 3];
			mag_pg[i] = vpe_mag(pre[i], pim[i]);
			mag_pp[i] = vt_delta ? mag_pg[i] : vpe_mag(dre[i], dim[i]);
		end
		mag_n = vt_delta ? '0 : vpe_mag(pre[0] + pre[1] + pre[2], pim[0] + pim[1] + pim[2]);
		mag_x = vpe_mag(SUMW'(vx_re), SUMW'(vx_im));
		for (int i = 0; i < 3; i++) begin
			if (vt_delta || phase_uv_phase_to_phase) begin
				next_uv_level[i] = LW'(mag_pp[i]) * PU_SCALE;
			end else begin
				next_uv_level[i] = LW'(mag_pg[i]) * PU_SCALE;
			end
			next_ov_level[i] = LW'(mag_pp[i]) * PU_SCALE;
		end
		next_n_level = LW'(mag_n) * PU_SCALE;
		next_x_level = LW'(mag_x) * PU_SCALE;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 3; i++) begin
				uv_level[i] <= '0;
				ov_level[i] <= '0;
			end
			n_level <= '0;
			x_level <= '0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				uv_level[i] <= next_uv_level[i];
				ov_level[i] <= next_ov_level[i];
			end
			n_level <= next_n_level;
			x_level <= next_x_level;
		end
	end

	// ******************************************************
	// Settings in level units
	// ******************************************************
	logic [LW-1:0] uv_set, uv_min, ov_set, n_set, xu_set, xu_min, xo_set;
	logic [DW-1:0] uv_dly, ov_dly, n_dly, xu_dly, xo_dly;
	logic n_allowed;

	always_comb begin
		uv_set = LW'(phase_uv_pickup_level) * LW'(phase_transformer_nominal_secondary);
		uv_min = LW'(phase_uv_min_level) * LW'(phase_transformer_nominal_secondary);
		ov_set = LW'(phase_ov_pickup_level) * LW'(phase_transformer_nominal_secondary);
		n_set = LW'(neutral_ov_pickup_level) * LW'(phase_transformer_nominal_secondary);
		xu_set = LW'(aux_under_pickup_level) * LW'(aux_transformer_nominal_secondary);
		xu_min = LW'(aux_under_min_level) * LW'(aux_transformer_nominal_secondary);
		xo_set = LW'(aux_ov_pickup_level) * LW'(aux_transformer_nominal_secondary);
		uv_dly = (phase_uv_delay_time > DELAY_MAX_STEPS) ? DELAY_MAX_STEPS : phase_uv_delay_time;
		ov_dly = (phase_ov_delay_time > DELAY_MAX_STEPS) ? DELAY_MAX_STEPS : phase_ov_delay_time;
		n_dly = (neutral_ov_delay_time > DELAY_MAX_STEPS) ? DELAY_MAX_STEPS : neutral_ov_delay_time;
		xu_dly = (aux_under_delay_time > DELAY_MAX_STEPS) ? DELAY_MAX_STEPS : aux_under_delay_time;
		xo_dly = (aux_ov_delay_time > DELAY_MAX_STEPS) ? DELAY_MAX_STEPS : aux_ov_delay_time;
		n_allowed = neutral_ov_enable && !vt_delta;
	end

	// ******************************************************
	// Elements
	// ******************************************************
	logic [2:0] uv_pu, uv_op, ov_pu, ov_op;
	logic next_uv_any, next_ov_any;

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_phase
			vpe_timer u_uv (
				.clk(clk),
				.rst(rst),
				.tick(tick),
				.enable(phase_uv_enable),
				.block(phase_uv_block),
				.over(1'b0),
				.inverse(phase_uv_inverse),
				.level(uv_level[g]),
				.setpoint(uv_set),
				.min_level(uv_min),
				.delay(uv_dly),
				.pickup(uv_pu[g]),
				.operate(uv_op[g])
			);
			vpe_timer u_ov (
				.clk(clk),
				.rst(rst),
				.tick(tick),
				.enable(phase_ov_enable),
				.block(phase_ov_block),
				.over(1'b1),
				.inverse(1'b0),
				.level(ov_level[g]),
				.setpoint(ov_set),
				.min_level('0),
				.delay(ov_dly),
				.pickup(ov_pu[g]),
				.operate(ov_op[g])
			);
		end
	endgenerate

	vpe_timer u_neutral_ov (
		.clk(clk),
		.rst(rst),
		.tick(tick),
		.enable(n_allowed),
		.block(neutral_ov_block),
		.over(1'b1),
		.inverse(1'b0),
		.level(n_level),
		.setpoint(n_set),
		.min_level('0),
		.delay(n_dly),
		.pickup(neutral_ov_pickup),
		.operate(neutral_ov_operate)
	);

	vpe_timer u_aux_uv (
		.clk(clk),
		.rst(rst),
		.tick(tick),
		.enable(aux_uv_enable),
		.block(aux_uv_block),
		.over(1'b0),
		.inverse(aux_uv_inverse),
		.level(x_level),
		.setpoint(xu_set),
		.min_level(xu_min),
		.delay(xu_dly),
		.pickup(aux_uv_pickup),
		.operate(aux_uv_operate)
	);

	vpe_timer u_aux_ov (
		.clk(clk),
		.rst(rst),
		.tick(tick),
		.enable(aux_ov_enable),
		.block(aux_ov_block),
		.over(1'b1),
		.inverse(1'b0),
		.level(x_level),
		.setpoint(xo_set),
		.min_level('0),
		.delay(xo_dly),
		.pickup(aux_ov_pickup),
		.operate(aux_ov_operate)
	);

	assign phase_uv_pickup = uv_pu;
	assign phase_uv_phase_operate = uv_op;
	assign phase_ov_pickup = ov_pu;
	assign phase_ov_phase_operate = ov_op;

	// ******************************************************
	// Combined phase operate flags
	// ******************************************************
	always_comb begin
		next_uv_any = |uv_op;
		next_ov_any = |ov_op;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_uv_operate <= 1'b0;
			phase_ov_operate <= 1'b0;
		end else begin
			phase_uv_operate <= next_uv_any;
			phase_ov_operate <= next_ov_any;
		end
	end

	// ******************************************************
	// Checks
	// ******************************************************
	property p_tick_period;
		@(posedge clk) disable iff (rst) tick |=> !tick;
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("Step enable lasted more than one cycle.");

	property p_uv_min_block;
		@(posedge clk) disable iff (rst) (uv_min != '0) && (uv_level[0] < uv_min) |=> !uv_pu[0];
	endproperty
	a_uv_min_block: assert property (p_uv_min_block) else $error("Phase undervoltage not blocked below minimum.");

	property p_aux_min_block;
		@(posedge clk) disable iff (rst) (x_level < xu_min) |=> !aux_uv_pickup && !aux_uv_operate;
	endproperty
	a_aux_min_block: assert property (p_aux_min_block) else $error("Aux undervoltage not blocked below minimum.");

	property p_neutral_delta;
		@(posedge clk) disable iff (rst) vt_delta ##1 vt_delta |-> !neutral_ov_pickup;
	endproperty
	a_neutral_delta: assert property (p_neutral_delta) else $error("Neutral overvoltage active on delta.");

	property p_aux_uv_start;
		@(posedge clk) disable iff (rst) aux_uv_enable && !aux_uv_block && (x_level < xu_set) && (x_level >= xu_min)
			|=> aux_uv_pickup;
	endproperty
	a_aux_uv_start: assert property (p_aux_uv_start) else $error("Aux undervoltage did not start timing.");

	property p_uv_any;
		@(posedge clk) disable iff (rst) (|uv_op) |=> phase_uv_operate;
	endproperty
	a_uv_any: assert property (p_uv_any) else $error("Phase undervoltage operate not combined.");

	property p_ov_instant;
		@(posedge clk) disable iff (rst) phase_ov_enable && !phase_ov_block && (ov_dly == '0) && (ov_level[1] > ov_set)
			##1 phase_ov_enable && !phase_ov_block && (ov_dly == '0) && (ov_level[1] > ov_set) |=> ov_op[1];
	endproperty
	a_ov_instant: assert property (p_ov_instant) else $error("Instantaneous overvoltage did not operate.");

endmodule
`default_nettype wire

// *** tb/vpe_vt_model.sv ***
// Behavioural voltage transformer channels: magnitudes in, phasors out at 0, -120 and +120 degrees.
`timescale 1ns/10ps
`default_nettype none
module vpe_vt_model (
	input wire logic [15:0] mag_a,
	input wire logic [15:0] mag_b,
	input wire logic [15:0] mag_c,
	input wire logic [15:0] mag_x,
	output logic signed [vpe_pkg::VW-1:0] va_re,
	output logic signed [vpe_pkg::VW-1:0] va_im,
	output logic signed [vpe_pkg::VW-1:0] vb_re,
	output logic signed [vpe_pkg::VW-1:0] vb_im,
	output logic signed [vpe_pkg::VW-1:0] vc_re,
	output logic signed [vpe_pkg::VW-1:0] vc_im,
	output logic signed [vpe_pkg::VW-1:0] vx_re,
	output logic signed [vpe_pkg::VW-1:0] vx_im
);
	import vpe_pkg::*;
	// The sine of 120 degrees is taken as 887/1024.
	always_comb begin
		va_re = VW'(mag_a);
		va_im = 16'h0000;
		vb_re = -VW'(mag_b >> 1);
		vb_im = -VW'((32'(mag_b) * 32'h0000_0377) >> 10);
		vc_re = -VW'(mag_c >> 1);
		vc_im = VW'((32'(mag_c) * 32'h0000_0377) >> 10);
		vx_re = VW'(mag_x);
		vx_im = 16'h0000;
	end
endmodule
`default_nettype wire

// *** tb/vpe_top_tb.sv ***
// Self-checking bench of the voltage protection elements with random and corner stimulus.
`timescale 1ns/10ps
`default_nettype none
module vpe_top_tb;
	import vpe_pkg::*;
	localparam int S = 10;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic vt_delta = 1'b0;
	logic phase_uv_phase_to_phase = 1'b0;
	logic [15:0] ma = 16'h03e8;
	logic [15:0] mb = 16'h03e8;
	logic [15:0] mc = 16'h03e8;
	logic [15:0] mx = 16'h01f4;
	logic signed [VW-1:0] va_re, va_im, vb_re, vb_im, vc_re, vc_im, vx_re, vx_im;
	logic [NW-1:0] phase_transformer_nominal_secondary = 16'h03e8;
	logic [NW-1:0] aux_transformer_nominal_secondary = 16'h01f4;
	logic [4:0] en = 5'h1f;
	logic [4:0] blk = 5'h00;
	logic phase_uv_inverse = 1'b0;
	logic aux_uv_inverse = 1'b0;
	logic [PW-1:0] phase_uv_pickup_level = 12'h320;
	logic [PW-1:0] phase_uv_min_level = 12'h12c;
	logic [DW-1:0] phase_uv_delay_time = 16'h0003;
	logic [PW-1:0] phase_ov_pickup_level = 12'h76c;
	logic [DW-1:0] phase_ov_delay_time = 16'h0000;
	logic [PW-1:0] neutral_ov_pickup_level = 12'h1f4;
	logic [DW-1:0] neutral_ov_delay_time = 16'h0001;
	logic [PW-1:0] aux_under_pickup_level = 12'h1f4;
	logic [PW-1:0] aux_under_min_level = 12'h0c8;
	logic [DW-1:0] aux_under_delay_time = 16'h0002;
	logic [PW-1:0] aux_ov_pickup_level = 12'h5dc;
	logic [DW-1:0] aux_ov_delay_time = 16'h0000;
	logic [2:0] phase_uv_pickup, phase_uv_phase_operate, phase_ov_pickup, phase_ov_phase_operate;
	logic phase_uv_operate, phase_ov_operate, neutral_ov_pickup, neutral_ov_operate;
	logic aux_uv_pickup, aux_uv_operate, aux_ov_pickup, aux_ov_operate;
	int fail_count = 0;
	int compares = 0;
	int cycles = 0;
	int d;
	logic [7:0] rnd = 8'h4c;

	vpe_vt_model vt_u (.mag_a(ma), .mag_b(mb), .mag_c(mc), .mag_x(mx), .va_re, .va_im, .vb_re, .vb_im,
		.vc_re, .vc_im, .vx_re, .vx_im);
	vpe_top #(.STEP_CYCLES_P(S)) dut_u (.clk, .rst, .vt_delta, .phase_uv_phase_to_phase, .va_re, .va_im,
		.vb_re, .vb_im, .vc_re, .vc_im, .vx_re, .vx_im, .phase_transformer_nominal_secondary,
		.aux_transformer_nominal_secondary, .phase_uv_enable(en[0]), .phase_uv_block(blk[0]), .phase_uv_inverse,
		.phase_uv_pickup_level, .phase_uv_min_level, .phase_uv_delay_time, .phase_ov_enable(en[4]),
		.phase_ov_block(blk[4]), .phase_ov_pickup_level, .phase_ov_delay_time, .neutral_ov_enable(en[1]),
		.neutral_ov_block(blk[1]), .neutral_ov_pickup_level, .neutral_ov_delay_time, .aux_uv_enable(en[2]),
		.aux_uv_block(blk[2]), .aux_uv_inverse, .aux_under_pickup_level, .aux_under_min_level,
		.aux_under_delay_time, .aux_ov_enable(en[3]), .aux_ov_block(blk[3]), .aux_ov_pickup_level,
		.aux_ov_delay_time, .phase_uv_pickup, .phase_uv_phase_operate, .phase_uv_operate, .phase_ov_pickup,
		.phase_ov_phase_operate, .phase_ov_operate, .neutral_ov_pickup, .neutral_ov_operate, .aux_uv_pickup,
		.aux_uv_operate, .aux_ov_pickup, .aux_ov_operate);

	always #2.5 clk = ~clk;

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			conclude();
		end
	end

	// ******************************************************
	// Helpers
	// ******************************************************
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	function automatic int lo(input int k);
		return (k == 0) ? 0 : (k - 1) * S;
	endfunction

	function automatic logic pk(input int s);
		case (s)
			0: return phase_uv_pickup[0];
			1: return neutral_ov_pickup;
			2: return aux_uv_pickup;
			3: return aux_ov_pickup;
			default: return phase_ov_pickup[0];
		endcase
	endfunction

	function automatic logic op(input int s);
		case (s)
			0: return phase_uv_operate;
			1: return neutral_ov_operate;
			2: return aux_uv_operate;
			3: return aux_ov_operate;
			default: return phase_ov_operate;
		endcase
	endfunction

	task automatic check(input string what, input logic [2:0] exp, input logic [2:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic done(input string name);
		$display("test %s finished", name);
	endtask

	// Waits for pickup, then checks that operate comes inside the window of m*d steps.
	task automatic timed(input int s, input int d, input int m);
		int n;
		n = 0;
		while (pk(s) !== 1'b1 && n < 6) begin
			tick(1);
			n++;
		end
		check("pickup", 3'h1, {2'h0, pk(s)});
		n = 0;
		while (op(s) !== 1'b1 && n < m * d * S + 20) begin
			tick(1);
			n++;
		end
		check("op_time", 3'h1, {2'h0, n >= lo(m * d) && n <= m * d * S + 3});
	endtask

	task automatic conclude();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ******************************************************
	// Tests
	// ******************************************************
	initial begin
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		tick(3);
		check("idle", 3'h0, phase_uv_pickup | phase_ov_pickup | {neutral_ov_pickup, aux_uv_pickup, aux_ov_pickup});
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			d = 1 + int'(rnd[1:0]);
			phase_uv_delay_time = 16'(d);
			ma = 16'h0136 + 16'(rnd);
			timed(0, d, 1);
			ma = 16'h03e8;
			tick(3);
			check("uv_recover", 3'h0, {phase_uv_pickup[0], phase_uv_phase_operate[0], phase_uv_operate});
		end
		done("uv_definite");
		phase_uv_delay_time = 16'h0000;
		ma = 16'h0190;
		timed(0, 0, 1);
		ma = 16'h0064;
		tick(6);
		check("uv_min_block", 3'h0, phase_uv_pickup);
		phase_uv_min_level = 12'h000;
		phase_uv_delay_time = 16'h0003;
		phase_uv_inverse = 1'b1;
		ma = 16'h0000;
		timed(0, 3, 1);
		ma = 16'h03e8;
		tick(3);
		ma = 16'h0190;
		timed(0, 3, 2);
		ma = 16'h03e8;
		phase_uv_inverse = 1'b0;
		phase_uv_min_level = 12'h12c;
		done("uv_inverse");
		phase_uv_phase_to_phase = 1'b1;
		phase_uv_pickup_level = 12'h4b0;
		ma = 16'h0000;
		tick(5);
		check("uv_star_pp", 3'h5, phase_uv_pickup);
		phase_uv_phase_to_phase = 1'b0;
		phase_uv_pickup_level = 12'h320;
		en[1] = 1'b0;
		vt_delta = 1'b1;
		ma = 16'h01f4;
		tick(5);
		check("delta_uv", 3'h1, phase_uv_pickup);
		ma = 16'h07d0;
		tick(5);
		check("delta_ov", 3'h1, phase_ov_pickup);
		ma = 16'h03e8;
		vt_delta = 1'b0;
		en[1] = 1'b1;
		tick(3);
		done("connections");
		ma = 16'h0514;
		timed(4, 0, 1);
		check("ov_star_pp", 3'h5, phase_ov_pickup);
		check("ov_star_op", 3'h5, phase_ov_phase_operate);
		blk[4] = 1'b1;
		tick(3);
		check("ov_blocked", 3'h0, phase_ov_pickup | phase_ov_phase_operate);
		blk[4] = 1'b0;
		ma = 16'h03e8;
		tick(3);
		phase_ov_delay_time = 16'h0002;
		ma = 16'h0514;
		timed(4, 2, 1);
		ma = 16'h03e8;
		done("phase_ov");
		neutral_ov_pickup_level = 12'h44c;
		ma = 16'h0000;
		tick(5);
		check("neutral_below", 3'h0, {2'h0, neutral_ov_pickup});
		neutral_ov_pickup_level = 12'h1f4;
		timed(1, 1, 1);
		ma = 16'h03e8;
		done("neutral_ov");
		mx = 16'h00c8;
		timed(2, 2, 1);
		mx = 16'h01f4;
		tick(3);
		check("aux_recover", 3'h0, {1'b0, aux_uv_pickup, aux_uv_operate});
		mx = 16'h0032;
		tick(5);
		check("aux_min_block", 3'h0, {2'h0, aux_uv_pickup});
		aux_uv_inverse = 1'b1;
		aux_under_delay_time = 16'h0001;
		mx = 16'h007d;
		timed(2, 1, 2);
		aux_uv_inverse = 1'b0;
		aux_under_delay_time = 16'h0002;
		mx = 16'h02bc;
		tick(5);
		check("aux_ov_below", 3'h0, {2'h0, aux_ov_pickup});
		mx = 16'h0320;
		timed(3, 0, 1);
		done("aux");
		phase_uv_min_level = 12'h000;
		ma = 16'h0000;
		mx = 16'h00c8;
		tick(40);
		check("all_operate", 3'h7, {phase_uv_operate, neutral_ov_operate, aux_uv_operate});
		for (int k = 0; k < 3; k++) begin
			blk[k] = 1'b1;
			tick(3);
			check("blocked", 3'h0, {2'h0, op(k)});
			blk[k] = 1'b0;
			en[k] = 1'b0;
			tick(3);
			check("disabled", 3'h0, {2'h0, pk(k)});
			en[k] = 1'b1;
		end
		tick(40);
		rst = 1'b1;
		tick(1);
		check("reset", 3'h0, {phase_uv_operate | phase_uv_pickup[0], neutral_ov_operate, aux_uv_operate});
		rst = 1'b0;
		tick(2);
		done("block_reset");
		conclude();
	end
endmodule
`default_nettype wire
